/* File: src/alu_datapath.sv */
// Integer datapath: arithmetic, logic, shifts, leading zeros, compares
// and moves, driven through an AXI4-Lite register file.
// Assumes one clock, synchronous active-low reset, one write and one
// read under way at a time.
//
// How it works
// - Arithmetic with flag request updates all four flags
// - AND, xor and or act bitwise
// - Bit clear ANDs with complemented second operand
// - Or-not ORs with complemented second operand
// - Flagged logic sets N, Z; V kept
// - Register shift amount uses low byte only
// - Rotate-extend shifts one right, carry enters top
// - Shift result written; source register untouched
// - Flagged shifts: N, Z, carry last out
// - Leading zeros: 32 for zero, 0 if top
// - Leading-zero count never changes flags
// - Compare subtracts, sets flags, writes nothing
// - Compare-negative adds, sets flags, writes nothing
// - Compares always update all four flags
// - Move copies second operand unchanged
// - Move-inverted writes complemented second operand
// - Wide move writes zero-extended 16-bit immediate
// - Move to program counter clears bit zero
// - Add takes second operand or 12-bit immediate
// - Add-with-carry adds carry flag too
// - Subtract-with-carry takes one more if carry clear
// - Reverse subtract: second minus first operand
module alu_datapath
    import alu_pkg::*;
(
    input  logic              clk,
    input  logic              rstn,
    input  logic [ADDR_W-1:0] s_axi_awaddr,
    input  logic [2:0]        s_axi_awprot,
    input  logic              s_axi_awvalid,
    output logic              s_axi_awready,
    input  logic [DATA_W-1:0] s_axi_wdata,
    input  logic [STRB_W-1:0] s_axi_wstrb,
    input  logic              s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  logic              s_axi_bready,
    input  logic [ADDR_W-1:0] s_axi_araddr,
    input  logic [2:0]        s_axi_arprot,
    input  logic              s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  logic              s_axi_rready,
    output logic [DATA_W-1:0] dest_value,
    output logic              dest_write,
    output flags_s            flags,
    output logic              branch_req,
    output logic [DATA_W-1:0] branch_addr
);

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] data,
                                                input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_word(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
        return addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
    endfunction

    function automatic add_s add_flags(input logic [DATA_W-1:0] x,
                                       input logic [DATA_W-1:0] y,
                                       input logic              cin);
        add_s              r;
        logic [DATA_W:0]   s;
        s       = {1'b0, x} + {1'b0, y} + {{DATA_W{1'b0}}, cin};
        r.sum   = s[DATA_W-1:0];
        r.fl.n  = s[DATA_W-1];
        r.fl.z  = (s[DATA_W-1:0] == '0);
        r.fl.c  = s[DATA_W];
        r.fl.v  = (x[DATA_W-1] == y[DATA_W-1]) && (s[DATA_W-1] != x[DATA_W-1]);
        return r;
    endfunction

    function automatic flags_s nz_flags(input logic [DATA_W-1:0] val,
                                        input flags_s            old);
        flags_s r;
        r   = old;
        r.n = val[DATA_W-1];
        r.z = (val == '0);
        return r;
    endfunction

    // Write channel capture
    logic              aw_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_full_q;
    logic [DATA_W-1:0] w_data_q;
    logic [STRB_W-1:0] w_strb_q;
    logic              do_write;
    logic              exec;

    // Software-visible state
    logic [DATA_W-1:0] first_q;
    logic [DATA_W-1:0] flex_q;
    logic [DATA_W-1:0] amt_reg_q;
    cmd_s              cmd_q;
    logic [1:0]        status_q;

    // Execution terms
    cmd_s              cmd_new;
    logic [DATA_W-1:0] flex_eff;
    logic [DATA_W-1:0] add_x;
    logic [DATA_W-1:0] add_y;
    logic              add_cin;
    add_s              add_r;
    shift_kind_e       sh_kind;
    logic [AMT_W-1:0]  sh_amt;
    logic [DATA_W-1:0] sh_result;
    logic              sh_carry;
    logic              sh_carry_valid;
    logic [CLZ_W-1:0]  lz_count;
    logic [DATA_W-1:0] ex_result;
    logic              ex_write;
    logic              ex_branch;
    flags_s            ex_flags;
    logic [DATA_W-1:0] flags_wr;
    logic              wr_mapped;
    logic [DATA_W-1:0] rd_data;
    logic              rd_mapped;

    assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    assign exec     = do_write && is_word(aw_addr_q, OFS_COMMAND);
    assign cmd_new  = cmd_s'(merge(DATA_W'(cmd_q), w_data_q, w_strb_q));
    assign flags_wr = merge({{(DATA_W-4){1'b0}}, flags}, w_data_q, w_strb_q);

    assign wr_mapped = is_word(aw_addr_q, OFS_FIRST_OPERAND) ||
                       is_word(aw_addr_q, OFS_FLEX_OPERAND)  ||
                       is_word(aw_addr_q, OFS_SHIFT_AMOUNT)  ||
                       is_word(aw_addr_q, OFS_COMMAND)       ||
                       is_word(aw_addr_q, OFS_FLAGS);

    // Immediate form of the second operand
    assign flex_eff = cmd_new.use_imm ?
                      {{(DATA_W-IMM12_W){1'b0}}, cmd_new.imm[IMM12_W-1:0]} :
                      flex_q;

    // Shared adder: subtraction is x + ~y + carry-in
    always_comb begin
        add_x   = first_q;
        add_y   = flex_eff;
        add_cin = 1'b0;
        unique case (cmd_new.op)
            OP_ADD_CARRY: begin
                add_cin = flags.c;
            end
            OP_SUBTRACT, OP_COMPARE: begin
                add_y   = ~flex_eff;
                add_cin = 1'b1;
            end
            OP_SUB_CARRY: begin
                add_y   = ~flex_eff;
                add_cin = flags.c;
            end
            OP_REVERSE_SUB: begin
                add_x   = flex_eff;
                add_y   = ~first_q;
                add_cin = 1'b1;
            end
            default: begin
                add_cin = 1'b0;
            end
        endcase
    end

    assign add_r = add_flags(add_x, add_y, add_cin);

    // A 6-bit immediate holds 32 for the right shifts
    always_comb begin
        sh_amt = cmd_new.amt_from_reg ? amt_reg_q[AMT_W-1:0] :
                 {2'b00, cmd_new.shift_imm};
        unique case (cmd_new.op)
            OP_ARITH_SHR:    sh_kind = SHIFT_RIGHT_ARITH;
            OP_LOGIC_SHR:    sh_kind = SHIFT_RIGHT_LOGIC;
            OP_ROTATE_RIGHT: sh_kind = SHIFT_ROTATE;
            OP_ROTATE_EXT:   sh_kind = SHIFT_ROTATE_EXT;
            default:         sh_kind = SHIFT_LEFT;
        endcase
    end

    alu_shifter #(
        .WIDTH       (DATA_W)
    ) u_shifter (
        .value       (flex_q),
        .amount      (sh_amt),
        .kind        (sh_kind),
        .carry_in    (flags.c),
        .result      (sh_result),
        .carry_out   (sh_carry),
        .carry_valid (sh_carry_valid)
    );

    leading_zero_counter #(
        .WIDTH (DATA_W),
        .CNT_W (CLZ_W)
    ) u_lzc (
        .value (flex_q),
        .count (lz_count)
    );

    // Result, write-back and flag selection; no flexible-operand shifter,
    // so flagged logic ops keep C as it was
    always_comb begin
        ex_result = add_r.sum;
        ex_write  = 1'b1;
        ex_branch = 1'b0;
        ex_flags  = flags;
        unique case (cmd_new.op)
            OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_SUB_CARRY, OP_REVERSE_SUB: begin
                if (cmd_new.set_flags) begin
                    ex_flags = add_r.fl;
                end
            end
            OP_AND, OP_LOGIC_XOR, OP_LOGIC_OR, OP_BIT_CLEAR, OP_OR_NOT: begin
                unique case (cmd_new.op)
                    OP_AND:       ex_result = first_q & flex_eff;
                    OP_LOGIC_XOR: ex_result = first_q ^ flex_eff;
                    OP_LOGIC_OR:  ex_result = first_q | flex_eff;
                    OP_BIT_CLEAR: ex_result = first_q & ~flex_eff;
                    default:      ex_result = first_q | ~flex_eff;
                endcase
                if (cmd_new.set_flags) begin
                    ex_flags = nz_flags(ex_result, flags);
                end
            end
            OP_ARITH_SHR, OP_LOGIC_SHL, OP_LOGIC_SHR, OP_ROTATE_RIGHT,
            OP_ROTATE_EXT: begin
                ex_result = sh_result;
                if (cmd_new.set_flags) begin
                    ex_flags = nz_flags(ex_result, flags);
                    if (sh_carry_valid) begin
                        ex_flags.c = sh_carry;
                    end
                end
            end
            OP_LEAD_ZEROS: begin
                ex_result = {{(DATA_W-CLZ_W){1'b0}}, lz_count};
            end
            OP_COMPARE, OP_COMPARE_NEG: begin
                ex_write = 1'b0;
                ex_flags = add_r.fl;
            end
            OP_MOVE, OP_MOVE_INV: begin
                ex_result = (cmd_new.op == OP_MOVE) ? flex_eff :
                            ~flex_eff;
                if (cmd_new.set_flags) begin
                    ex_flags = nz_flags(ex_result, flags);
                end
                if (cmd_new.op == OP_MOVE && cmd_new.dest_pc) begin
                    ex_result = ex_result & PC_ALIGN_MASK;
                    ex_write  = 1'b0;
                    ex_branch = 1'b1;
                    ex_flags  = flags;
                end
            end
            OP_MOVE_WIDE: begin
                ex_result = {{(DATA_W-IMM16_W){1'b0}}, cmd_new.imm};
            end
            default: begin
                ex_write = 1'b0;
            end
        endcase
    end

    // AXI write address and data, taken in either order
    always_ff @(posedge clk) begin
        if (!rstn) begin
            aw_full_q     <= 1'b0;
            aw_addr_q     <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_full_q     <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            w_full_q     <= 1'b0;
            w_data_q     <= '0;
            w_strb_q     <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_full_q     <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Operand registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            first_q   <= WORD_RESET;
            flex_q    <= WORD_RESET;
            amt_reg_q <= WORD_RESET;
        end else if (do_write) begin
            if (is_word(aw_addr_q, OFS_FIRST_OPERAND)) begin
                first_q <= merge(first_q, w_data_q, w_strb_q);
            end
            if (is_word(aw_addr_q, OFS_FLEX_OPERAND)) begin
                flex_q <= merge(flex_q, w_data_q, w_strb_q);
            end
            if (is_word(aw_addr_q, OFS_SHIFT_AMOUNT)) begin
                amt_reg_q <= merge(amt_reg_q, w_data_q, w_strb_q);
            end
        end
    end

    // Command write launches execution in the same edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cmd_q    <= cmd_s'(WORD_RESET);
            status_q <= '0;
        end else if (exec) begin
            cmd_q    <= cmd_new;
            status_q <= {ex_branch, ex_write};
        end
    end

    // Software writes and execution never share an edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags <= FLAGS_RESET;
        end else if (exec) begin
            flags <= ex_flags;
        end else if (do_write && is_word(aw_addr_q, OFS_FLAGS)) begin
            flags <= flags_s'(flags_wr[3:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dest_value  <= WORD_RESET;
            dest_write  <= 1'b0;
            branch_req  <= 1'b0;
            branch_addr <= WORD_RESET;
        end else begin
            dest_write <= exec && ex_write;
            branch_req <= exec && ex_branch;
            if (exec && ex_write) begin
                dest_value <= ex_result;
            end
            if (exec && ex_branch) begin
                branch_addr <= ex_result;
            end
        end
    end

    // AXI read
    always_comb begin
        rd_mapped = 1'b1;
        rd_data   = '0;
        if (is_word(s_axi_araddr, OFS_FIRST_OPERAND)) begin
            rd_data = first_q;
        end else if (is_word(s_axi_araddr, OFS_FLEX_OPERAND)) begin
            rd_data = flex_q;
        end else if (is_word(s_axi_araddr, OFS_SHIFT_AMOUNT)) begin
            rd_data = amt_reg_q;
        end else if (is_word(s_axi_araddr, OFS_COMMAND)) begin
            rd_data = DATA_W'(cmd_q);
        end else if (is_word(s_axi_araddr, OFS_RESULT)) begin
            rd_data = dest_value;
        end else if (is_word(s_axi_araddr, OFS_FLAGS)) begin
            rd_data = {{(DATA_W-4){1'b0}}, flags};
        end else if (is_word(s_axi_araddr, OFS_STATUS)) begin
            rd_data = {{(DATA_W-2){1'b0}}, status_q};
        end else if (is_word(s_axi_araddr, OFS_BRANCH)) begin
            rd_data = branch_addr;
        end else begin
            rd_mapped = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

/* File: shared/alu_pkg.sv */
// Constants, register map and carrier types of the integer datapath.
// Assumes a 32-bit AXI4-Lite master and one synchronous clock domain.
package alu_pkg;

    localparam int unsigned DATA_W  = 32;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned STRB_W  = DATA_W / 8;
    localparam int unsigned AMT_W   = 8;
    localparam int unsigned IMM12_W = 12;
    localparam int unsigned IMM16_W = 16;
    localparam int unsigned CLZ_W   = 6;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_FIRST_OPERAND = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLEX_OPERAND  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SHIFT_AMOUNT  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COMMAND       = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_RESULT        = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FLAGS         = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS        = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_BRANCH        = 8'h1C;

    // Reset values and field positions
    localparam logic [DATA_W-1:0] WORD_RESET    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PC_ALIGN_MASK = 32'hFFFF_FFFE;
    localparam int unsigned       STAT_WRITTEN  = 0;
    localparam int unsigned       STAT_BRANCH   = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        OP_ADD          = 5'h00,
        OP_ADD_CARRY    = 5'h01,
        OP_SUBTRACT     = 5'h02,
        OP_SUB_CARRY    = 5'h03,
        OP_REVERSE_SUB  = 5'h04,
        OP_AND          = 5'h05,
        OP_LOGIC_XOR    = 5'h06,
        OP_LOGIC_OR     = 5'h07,
        OP_BIT_CLEAR    = 5'h08,
        OP_OR_NOT       = 5'h09,
        OP_ARITH_SHR    = 5'h0A,
        OP_LOGIC_SHL    = 5'h0B,
        OP_LOGIC_SHR    = 5'h0C,
        OP_ROTATE_RIGHT = 5'h0D,
        OP_ROTATE_EXT   = 5'h0E,
        OP_LEAD_ZEROS   = 5'h0F,
        OP_COMPARE      = 5'h10,
        OP_COMPARE_NEG  = 5'h11,
        OP_MOVE         = 5'h12,
        OP_MOVE_INV     = 5'h13,
        OP_MOVE_WIDE    = 5'h14
    } alu_op_e;

    typedef enum logic [2:0] {
        SHIFT_LEFT        = 3'h0,
        SHIFT_RIGHT_LOGIC = 3'h1,
        SHIFT_RIGHT_ARITH = 3'h2,
        SHIFT_ROTATE      = 3'h3,
        SHIFT_ROTATE_EXT  = 3'h4
    } shift_kind_e;

    // Command word, bit 31 down to bit 0
    typedef struct packed {
        logic [IMM16_W-1:0] imm;
        logic               spare;
        logic [5:0]         shift_imm;
        logic               use_imm;
        logic               dest_pc;
        logic               amt_from_reg;
        logic               set_flags;
        alu_op_e            op;
    } cmd_s;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } flags_s;

    typedef struct packed {
        flags_s            fl;
        logic [DATA_W-1:0] sum;
    } add_s;

    localparam flags_s FLAGS_RESET = 4'h0;

endpackage

/* File: src/alu_shifter.sv */
// Barrel shifter with carry-out for the shift and rotate operations.
// Assumes amount is the full 0..255 shift length; purely combinational.
module alu_shifter
    import alu_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_W
)(
    input  logic [WIDTH-1:0] value,
    input  logic [AMT_W-1:0] amount,
    input  shift_kind_e      kind,
    input  logic             carry_in,
    output logic [WIDTH-1:0] result,
    output logic             carry_out,
    output logic             carry_valid
);
    localparam int unsigned ROT_W = $clog2(WIDTH);

    logic [WIDTH:0]   wide;
    logic [ROT_W-1:0] rot;

    always_comb begin
        wide        = '0;
        rot         = amount[ROT_W-1:0];
        result      = value;
        carry_out   = carry_in;
        carry_valid = (amount != '0);
        unique case (kind)
            SHIFT_LEFT: begin
                wide      = {1'b0, value} << amount;
                result    = wide[WIDTH-1:0];
                carry_out = wide[WIDTH];
            end
            SHIFT_RIGHT_LOGIC: begin
                wide      = {value, 1'b0} >> amount;
                result    = wide[WIDTH:1];
                carry_out = wide[0];
            end
            SHIFT_RIGHT_ARITH: begin
                wide      = $signed({value, 1'b0}) >>> amount;
                result    = wide[WIDTH:1];
                carry_out = wide[0];
            end
            SHIFT_ROTATE: begin
                result    = (value >> rot) | (value << (WIDTH - rot));
                carry_out = result[WIDTH-1];
            end
            SHIFT_ROTATE_EXT: begin
                result      = {carry_in, value[WIDTH-1:1]};
                carry_out   = value[0];
                carry_valid = 1'b1;
            end
            default: begin
                result = value;
            end
        endcase
        if (!carry_valid) begin
            result    = value;
            carry_out = carry_in;
        end
    end

endmodule

/* File: src/leading_zero_counter.sv */
// Count of zero bits above the highest set bit.
// Assumes nothing of its surroundings; purely combinational.
module leading_zero_counter
    import alu_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_W,
    parameter int unsigned CNT_W = CLZ_W
)(
    input  logic [WIDTH-1:0] value,
    output logic [CNT_W-1:0] count
);
    always_comb begin
        count = CNT_W'(WIDTH);
        for (int i = 0; i < WIDTH; i++) begin
            if (value[i]) begin
                count = CNT_W'(WIDTH - 1 - i);
            end
        end
    end

endmodule

/* File: test/alu_datapath_sva.sv */
// Bus and datapath timing checks for the integer datapath.
// Assumes the top module's ports only; bound at the foot of the file.
module alu_datapath_sva
    import alu_pkg::*;
(
    input logic              clk,
    input logic              rstn,
    input logic              s_axi_awvalid,
    input logic              s_axi_awready,
    input logic              s_axi_wvalid,
    input logic              s_axi_wready,
    input logic              s_axi_bvalid,
    input logic              s_axi_arvalid,
    input logic              s_axi_arready,
    input logic              s_axi_rvalid,
    input logic              dest_write,
    input flags_s            flags,
    input logic              branch_req,
    input logic [DATA_W-1:0] branch_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        ##[1:2] s_axi_bvalid;
    endsequence
    chk_b_answer: assert property (wr_taken |-> wr_answer)
        else $error("write answer missing");
    chk_aw_refuse: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
        else $error("write taken twice");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    chk_write_pulse: assert property (dest_write |=> !dest_write)
        else $error("write pulse too long");
    chk_pc_even: assert property (branch_req |-> !branch_addr[0])
        else $error("odd branch target");
    chk_flags_cause: assert property (!$stable(flags) |-> $rose(s_axi_bvalid))
        else $error("flags changed without command");
    chk_dest_cause: assert property (dest_write |-> $rose(s_axi_bvalid))
        else $error("write without command");
    chk_branch_nowr: assert property (branch_req |-> !dest_write)
        else $error("branch also wrote");
endmodule
bind alu_datapath alu_datapath_sva i_chk (.*);

/* File: test/axi_lite_master.sv */
// Issue-side model: AXI4-Lite master, one write and one read at a time.
// Assumes bready and rready are held high by the bench.
module axi_lite_master
    import alu_pkg::*;
(
    input  logic              clk,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic              s_axi_awvalid,
    input  logic              s_axi_awready,
    output logic [DATA_W-1:0] s_axi_wdata,
    output logic              s_axi_wvalid,
    input  logic              s_axi_wready,
    input  logic              s_axi_bvalid,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic              s_axi_arvalid,
    input  logic              s_axi_arready,
    input  logic [DATA_W-1:0] s_axi_rdata,
    input  logic [1:0]        s_axi_rresp,
    input  logic              s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    initial {s_axi_araddr, s_axi_arvalid} = '0;
    // Handshakes read at the falling edge, s_axi_arready at the rising edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic ka, kw, kb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge clk) {ka, kw, kb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge clk) if (ka) s_axi_awvalid <= 1'b0;
            if (kw) s_axi_wvalid <= 1'b0;
        end while (!kb);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic [1:0] r);
        logic k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk) {k, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clk) if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!k);
    endtask
endmodule

/* File: test/alu_datapath_tb_top.sv */
// Self-checking bench: datapath commands issued over AXI4-Lite.
// Assumes the master model drives the bus; bready and rready stay high.
module alu_datapath_tb_top import alu_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rstn = 0, s_axi_bready = 1, s_axi_rready = 1;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, dest_value, branch_addr, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, dest_write, branch_req;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
    flags_s flags;
    cmd_s k;
    int bad_count = 0, n_compared = 0, cyc = 0;
    always #12.5 clk = ~clk;
    alu_datapath i_dut (.*);
    axi_lite_master i_m (.*);
    task print_verdict;
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task cmp(input string n, input logic [DATA_W-1:0] e, s);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    function cmd_s c(alu_op_e o, logic f, logic [5:0] s = 6'h0, logic r = 1'b0,
                     logic [15:0] i = 16'h0);
        return '{i, 1'b0, s, i != 16'h0, 1'b0, r, f, o};
    endfunction
    task run(input cmd_s q, input logic [DATA_W-1:0] a, b, e, f);
        i_m.wr(OFS_FIRST_OPERAND, a);
        i_m.wr(OFS_FLEX_OPERAND, b);
        i_m.wr(OFS_COMMAND, q);
        i_m.rd(OFS_RESULT, rv, rr);
        cmp("result", e, rv);
        i_m.rd(OFS_FLAGS, rv, rr);
        cmp("flags", f, rv);
    endtask
    task t_arith;
        run(c(OP_ADD, 1, 0, 0, 16'h10), 1, 5, 17, 0);
        run(c(OP_REVERSE_SUB, 1), 1, 3, 2, 2);
        run(c(OP_SUBTRACT, 1), 5, 5, 0, 6);
        run(c(OP_ADD_CARRY, 1), 32'hFFFF_FFFF, 0, 0, 6);
        run(c(OP_SUB_CARRY, 1), 32'h8000_0000, 1, 32'h7FFF_FFFF, 3);
    endtask
    task t_logic;
        run(c(OP_AND, 0), 12, 10, 8, 3);
        run(c(OP_LOGIC_XOR, 0), 12, 10, 6, 3);
        run(c(OP_LOGIC_OR, 0), 12, 10, 14, 3);
        run(c(OP_MOVE_INV, 1), 0, -2, 1, 3);
        run(c(OP_BIT_CLEAR, 0), 32'hFF, 32'h0F, 32'hF0, 3);
        run(c(OP_OR_NOT, 1), 0, 32'h7FFF_FFFF, 32'h8000_0000, 32'hB);
    endtask
    task t_shift;
        run(c(OP_LOGIC_SHR, 1, 6'd32), 0, 32'h8000_0001, 0, 7);
        run(c(OP_ROTATE_EXT, 1), 0, 2, 32'h8000_0001, 9);
        run(c(OP_ARITH_SHR, 0, 6'd4), 0, -32, -2, 9);
        i_m.wr(OFS_SHIFT_AMOUNT, 32'h104);
        run(c(OP_ROTATE_RIGHT, 1, 6'd0, 1), 0, 32'hF1, 32'h1000_000F, 1);
        i_m.rd(OFS_FLEX_OPERAND, rv, rr);
        cmp("source", 32'hF1, rv);
    endtask
    task t_other;
        run(c(OP_LEAD_ZEROS, 0), 0, 0, 32'h20, 1);
        run(c(OP_COMPARE_NEG, 0), 2, 3, 32'h20, 0);
        run(c(OP_COMPARE, 0), 1, 2, 32'h20, 8);
        run(c(OP_MOVE_WIDE, 0, 0, 0, 16'hFFFF), 0, 0, 32'hFFFF, 8);
        k = c(OP_MOVE, 0);
        k.dest_pc = 1'b1;
        run(k, 0, 32'h1235, 32'hFFFF, 8);
        i_m.rd(OFS_BRANCH, rv, rr);
        cmp("branch", 32'h1234, rv);
        i_m.rd(8'h20, rv, rr);
        cmp("resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            print_verdict;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_arith;
        t_logic;
        t_shift;
        t_other;
        print_verdict;
    end
endmodule
